//--- design/bsc_top.v
`timescale 1ns/100ps
`include "bsc_defs.vh"
module bsc_top #(
   parameter FILTER_CYC = (`BSC_FILTER_NS + `BSC_CLK_NS - 1) / `BSC_CLK_NS,
   parameter PUD_CYC    = (`BSC_PUD_US * 1000 + `BSC_CLK_NS - 1) / `BSC_CLK_NS,
   parameter PUD_EN     = 1
) (
   // Clock and reset
   input  wire       clk,
   input  wire       rst_b,
   // Configuration and power state
   input  wire [1:0] brownout_mode_select,
   input  wire       sleep_active,
   input  wire       periph_ref_request,
   // Analog side
   input  wire       supply_low,
   input  wire       reference_stable_flag,
   output reg        fixed_voltage_reference_en,
   // Register port
   input  wire [3:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   // Results
   output reg        brownout_reset,
   output reg        brownout_flag,
   output reg        armed,
   output reg        irq
);

   function [7:0] pad8;
      input [3:0] v;
      begin
         pad8 = {4'h0, v};
      end
   endfunction

   wire       stable_s;
   wire       low_s;
   wire       tmr_done;
   wire       tmr_run;
   reg        soft_en_q;
   reg  [1:0] mode_q;
   reg  [7:0] filt_q;
   reg  [2:0] ist_q;
   reg  [2:0] mask_q;
   reg        arm_prev_q;
   reg        rst_prev_q;
   reg        enabled;
   reg        active;
   reg        filt_hit;
   reg  [2:0] ev;
   reg  [7:0] rd_d;

   bsc_sync u_sync_ref (
      .clk   (clk),
      .rst_b (rst_b),
      .din   (reference_stable_flag),
      .dout  (stable_s)
   );

   bsc_sync u_sync_low (
      .clk   (clk),
      .rst_b (rst_b),
      .din   (supply_low),
      .dout  (low_s)
   );

   // Mode sampled every cycle
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_q <= `BSC_MODE_OFF;
      end else begin
         mode_q <= brownout_mode_select;
      end
   end

   // Arming decision
   always @* begin
      case (mode_q)
         `BSC_MODE_OFF:      enabled = 1'b0;
         `BSC_MODE_SOFT:     enabled = soft_en_q;
         `BSC_MODE_HW_SLEEP: enabled = ~sleep_active;
         `BSC_MODE_HW_ALWAYS: enabled = 1'b1;
         default:            enabled = 1'b0;
      endcase
      active = enabled & stable_s;
   end

   // Filter counter for supply drop
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         filt_q <= 8'h00;
      end else if (!active || !low_s) begin
         filt_q <= 8'h00;
      end else if (filt_q != FILTER_CYC[7:0]) begin
         filt_q <= filt_q + 8'h01;
      end
   end

   always @* begin
      filt_hit = active & low_s & (filt_q == FILTER_CYC[7:0]);
   end

   bsc_timer #(
      .W     (16),
      .COUNT (PUD_CYC)
   ) u_pud_tmr (
      .clk     (clk),
      .rst_b   (rst_b),
      .hold    (brownout_reset & low_s),
      .enable  (PUD_EN != 0),
      .done    (tmr_done),
      .running (tmr_run)
   );

   // Reset request, reference enable, armed, flag
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         brownout_reset             <= 1'b0;
         brownout_flag              <= 1'b0;
         fixed_voltage_reference_en <= 1'b0;
         armed                      <= 1'b0;
      end else begin
         fixed_voltage_reference_en <= enabled | periph_ref_request;
         armed <= active;
         if (filt_hit || (brownout_reset && tmr_run && low_s && enabled)) begin
            brownout_reset <= 1'b1;
         end else if (brownout_reset && !low_s && tmr_done) begin
            brownout_reset <= 1'b0;
         end else if (brownout_reset && !enabled) begin
            brownout_reset <= 1'b0;
         end
         if (filt_hit) begin
            brownout_flag <= 1'b0;
         end else if (reg_wr && reg_addr == `BSC_REG_CTRL && reg_wdata[`BSC_CTRL_FLAG_SET]) begin
            brownout_flag <= 1'b1;
         end
      end
   end

   // Software enable
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         soft_en_q <= 1'b0;
      end else if (reg_wr && reg_addr == `BSC_REG_CTRL) begin
         soft_en_q <= reg_wdata[`BSC_CTRL_SOFT_EN];
      end
   end

   // Interrupt events
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         arm_prev_q <= 1'b0;
         rst_prev_q <= 1'b0;
      end else begin
         arm_prev_q <= armed;
         rst_prev_q <= brownout_reset;
      end
   end

   always @* begin
      ev = 3'h0;
      ev[`BSC_IRQ_EVENT]   = brownout_reset & ~rst_prev_q;
      ev[`BSC_IRQ_ARMED]   = armed & ~arm_prev_q;
      ev[`BSC_IRQ_RELEASE] = ~brownout_reset & rst_prev_q;
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ist_q  <= 3'h0;
         mask_q <= `BSC_MASK_RST;
         irq    <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == `BSC_REG_IRQ_STAT) begin
            ist_q <= (ist_q & ~reg_wdata[2:0]) | ev;
         end else begin
            ist_q <= ist_q | ev;
         end
         if (reg_wr && reg_addr == `BSC_REG_IRQ_MASK) begin
            mask_q <= reg_wdata[2:0];
         end
         irq <= |(ist_q & mask_q);
      end
   end

   // Read mux
   always @* begin
      rd_d = 8'h00;
      case (reg_addr)
         `BSC_REG_CTRL: begin
            rd_d[`BSC_CTRL_SOFT_EN]   = soft_en_q & (mode_q == `BSC_MODE_SOFT);
            rd_d[`BSC_CTRL_FLAG_SET]  = brownout_flag;
         end
         `BSC_REG_VREF: begin
            rd_d[`BSC_VREF_REQ]    = fixed_voltage_reference_en;
            rd_d[`BSC_VREF_STABLE] = stable_s;
         end
         `BSC_REG_STATUS: begin
            rd_d[`BSC_ST_ARMED] = armed;
            rd_d[`BSC_ST_RESET] = brownout_reset;
            rd_d[`BSC_ST_FLAG]  = brownout_flag;
            rd_d[`BSC_ST_TIMER] = tmr_run;
         end
         `BSC_REG_IRQ_STAT: rd_d = pad8({1'b0, ist_q});
         `BSC_REG_IRQ_MASK: rd_d = pad8({1'b0, mask_q});
         default:           rd_d = 8'h00;
      endcase
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? rd_d : 8'h00;
      end
   end

endmodule

//--- shared/bsc_defs.vh
`ifndef BSC_DEFS_VH
`define BSC_DEFS_VH

// Mode field codes
`define BSC_MODE_OFF        2'h0
`define BSC_MODE_SOFT       2'h1
`define BSC_MODE_HW_SLEEP   2'h2
`define BSC_MODE_HW_ALWAYS  2'h3

// Register offsets
`define BSC_REG_CTRL        4'h0
`define BSC_REG_VREF        4'h1
`define BSC_REG_STATUS      4'h2
`define BSC_REG_IRQ_STAT    4'h3
`define BSC_REG_IRQ_MASK    4'h4

// Control register fields
`define BSC_CTRL_SOFT_EN    0
`define BSC_CTRL_FLAG_SET   1

// Voltage reference control register fields
`define BSC_VREF_REQ        7
`define BSC_VREF_STABLE     6

// Status register fields
`define BSC_ST_ARMED        0
`define BSC_ST_RESET        1
`define BSC_ST_FLAG         2
`define BSC_ST_TIMER        3

// Interrupt bits
`define BSC_IRQ_EVENT       0
`define BSC_IRQ_ARMED       1
`define BSC_IRQ_RELEASE     2
`define BSC_IRQ_W           3

// Reset values
`define BSC_CTRL_RST        8'h00
`define BSC_MASK_RST        3'h0

// Timing
`define BSC_CLK_NS          40
`define BSC_FILTER_NS       2000
`define BSC_PUD_US          66

`endif

//--- design/bsc_sync.v
`timescale 1ns/100ps
// Two flop synchroniser
module bsc_sync (
   // Clock and reset
   input  wire clk,
   input  wire rst_b,
   // Data
   input  wire din,
   output wire dout
);
   reg s1_q;
   reg s2_q;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
      end
   end
   assign dout = s2_q;
endmodule

//--- design/bsc_timer.v
`timescale 1ns/100ps
// Down counter, reloads while hold is high
module bsc_timer #(
   parameter W     = 16,
   parameter COUNT = 16
) (
   // Clock and reset
   input  wire         clk,
   input  wire         rst_b,
   // Control
   input  wire         hold,
   input  wire         enable,
   output wire         done,
   output wire         running
);
   reg  [W-1:0] cnt_q;
   wire [W-1:0] load = COUNT[W-1:0];
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= {W{1'b0}};
      end else if (hold) begin
         cnt_q <= enable ? load : {W{1'b0}};
      end else if (cnt_q != {W{1'b0}}) begin
         cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
   end
   assign done    = (cnt_q == {W{1'b0}});
   assign running = ~done;
endmodule

//--- test/bsc_analog_model.sv
`timescale 1ns/100ps
module bsc_analog_model (
   // Bench control
   input  wire       clk,
   input  wire       rst_b,
   input  wire [7:0] settle,
   input  wire       drop,
   // Device side
   input  wire       ref_en,
   output wire       stable,
   output wire       supply_low
);
   logic [7:0] cnt_q;
   // Comparator follows the supply directly
   assign supply_low = drop;
   // Reference settles some cycles after enable, lost at once when off
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) cnt_q <= 8'h00;
      else cnt_q <= ref_en ? cnt_q + {7'h00, cnt_q != 8'hFF} : 8'h00;
   end
   assign stable = ref_en && cnt_q >= settle;
endmodule

//--- test/bsc_top_chk.sv
`timescale 1ns/100ps
module bsc_top_chk #(parameter FILTER_CYC = 3, parameter PUD_CYC = 10) (
   // Watched ports
   input wire clk, input wire rst_b, input wire [1:0] brownout_mode_select, input wire sleep_active,
   input wire supply_low, input wire reference_stable_flag, input wire fixed_voltage_reference_en,
   input wire reg_rd, input wire [7:0] reg_rdata, input wire brownout_reset, input wire brownout_flag,
   input wire armed, input wire irq
);
   logic [15:0] lo_q, hi_q;
   // Consecutive low and high supply cycles
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lo_q <= 16'h0000;
         hi_q <= 16'h0000;
      end else begin
         lo_q <= supply_low ? lo_q + 16'h0001 : 16'h0000;
         hi_q <= supply_low ? 16'h0000 : hi_q + 16'h0001;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_ref_forced: assert property ((brownout_mode_select == 2'h3)[*3] |-> fixed_voltage_reference_en)
      else $error("reference off while enabled");
   a_stable_gate: assert property (!reference_stable_flag[*5] |-> !armed)
      else $error("armed without stable reference");
   a_off_idle: assert property ((brownout_mode_select == 2'h0)[*4] |-> !armed && !brownout_reset)
      else $error("armed in off mode");
   a_sleep_off: assert property ((brownout_mode_select == 2'h2 && sleep_active)[*3] |-> !armed)
      else $error("armed in sleep");
   a_hw_arm: assert property (((brownout_mode_select == 2'h3 || brownout_mode_select == 2'h2 && !sleep_active)
      && reference_stable_flag)[*5] |-> armed)
      else $error("not armed in hardware mode");
   a_rst_armed: assert property ($rose(brownout_reset) |-> $past(armed))
      else $error("reset while not armed");
   a_flag_clr: assert property ($rose(brownout_reset) |-> !brownout_flag)
      else $error("flag not cleared");
   a_filter_len: assert property ($rose(brownout_reset) |-> lo_q >= FILTER_CYC)
      else $error("reset before filter time");
   a_pud_len: assert property ($fell(brownout_reset) && armed |-> hi_q >= PUD_CYC)
      else $error("reset released early");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside slot");
   c_brownout: cover property ($rose(brownout_reset));
   c_sleep: cover property ($fell(armed) && sleep_active);
   c_irq: cover property ($rose(irq));
endmodule
bind bsc_top bsc_top_chk #(.FILTER_CYC(FILTER_CYC), .PUD_CYC(PUD_CYC)) chk (.clk, .rst_b,
   .brownout_mode_select, .sleep_active, .supply_low, .reference_stable_flag, .fixed_voltage_reference_en,
   .reg_rd, .reg_rdata, .brownout_reset, .brownout_flag, .armed, .irq);

//--- test/bsc_top_tb.sv
`timescale 1ns/100ps
module bsc_top_tb;
   localparam FC = 3, PC = 10;
   logic clk = 0, rst_b = 0, sleep_active = 0, periph_ref_request = 0, reg_wr = 0, reg_rd = 0, drop = 0;
   logic [1:0] brownout_mode_select = 2'h0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, settle = 8'h04, rd_q;
   logic [31:0] lfsr = 32'hCED14ED5;
   wire supply_low, reference_stable_flag, fixed_voltage_reference_en, brownout_reset, brownout_flag, armed, irq;
   wire [7:0] reg_rdata;
   int errors = 0, checks = 0, cyc = 0, n;
   initial forever #20 clk = ~clk;
   bsc_top #(.FILTER_CYC(FC), .PUD_CYC(PC)) dut (.clk, .rst_b, .brownout_mode_select, .sleep_active,
      .periph_ref_request, .supply_low, .reference_stable_flag, .fixed_voltage_reference_en, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .brownout_reset, .brownout_flag, .armed, .irq);
   bsc_analog_model model (.clk, .rst_b, .settle, .drop, .ref_en(fixed_voltage_reference_en),
      .stable(reference_stable_flag), .supply_low);
   function automatic logic [31:0] nxt(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cy(int k);
      repeat (k) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic wr(logic [3:0] a, logic [7:0] d);
      @(posedge clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge clk); reg_wr <= 1'b0;
      @(negedge clk);
   endtask
   task automatic rd(logic [3:0] a);
      @(posedge clk); reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clk); reg_rd <= 1'b0;
      @(negedge clk); rd_q = reg_rdata;
   endtask
   task automatic wait_arm(logic v);
      n = 0;
      while (armed !== v && n < 80) begin @(negedge clk); n++; end
      chk("armed", v, armed);
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin errors++; finish_test(); end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      rd(4'h0); chk("ctrl", 8'h00, rd_q);
      chk("flag", 8'h00, brownout_flag);
      rd(4'hF); chk("unmapped", 8'h00, rd_q);
      wr(4'h4, 8'h01);
      $display("end reset");
      // Hardware mode, filtered drop, timer reload
      brownout_mode_select <= 2'h3;
      wait_arm(1'b1);
      chk("ref_en", 8'h01, fixed_voltage_reference_en);
      rd(4'h1); chk("vref", 8'hC0, rd_q);
      wr(4'h0, 8'h02); chk("flag set", 8'h01, brownout_flag);
      wr(4'h3, 8'h07); lfsr = nxt(lfsr);
      drop <= 1'b1; cy(FC + 5 + lfsr[2:0]);
      chk("reset", 8'h01, brownout_reset);
      chk("flag clr", 8'h00, brownout_flag);
      chk("irq", 8'h01, irq);
      drop <= 1'b0; cy(PC / 2); drop <= 1'b1; cy(FC + 4); drop <= 1'b0;
      n = 0;
      while (brownout_reset === 1'b1 && n < 200) begin @(negedge clk); n++; end
      chk("pud timer", 8'h01, n >= PC && n <= PC + 6);
      wr(4'h3, 8'h01); cy(2); chk("irq clr", 8'h00, irq);
      $display("end hw");
      // Sleep disarms and wake re-arms
      brownout_mode_select <= 2'h2; sleep_active <= 1'b1;
      wait_arm(1'b0);
      drop <= 1'b1; cy(FC + 6);
      chk("ref off", 8'h00, fixed_voltage_reference_en);
      chk("sleep rst", 8'h00, brownout_reset);
      drop <= 1'b0; sleep_active <= 1'b0;
      wait_arm(1'b1);
      $display("end sleep");
      // Soft mode, disabled before settling
      settle <= 8'h3C; brownout_mode_select <= 2'h1; cy(4);
      wr(4'h0, 8'h01); rd(4'h0); chk("soft", 8'h01, rd_q);
      drop <= 1'b1; cy(20); chk("unsettled", 8'h00, brownout_reset);
      wr(4'h0, 8'h00); cy(60); chk("disabled", 8'h00, brownout_reset);
      drop <= 1'b0; lfsr = nxt(lfsr); settle <= {4'h0, lfsr[3:0]} + 8'h01;
      brownout_mode_select <= 2'h3; cy(2); wr(4'h0, 8'h01);
      rd(4'h0); chk("soft ro", 8'h00, rd_q);
      brownout_mode_select <= 2'h0; periph_ref_request <= 1'b1; cy(5);
      chk("off arm", 8'h00, armed);
      chk("periph ref", 8'h01, fixed_voltage_reference_en);
      $display("end soft");
      finish_test();
   end
endmodule
